// File: common/ovsr_pkg.sv
package ovsr_pkg;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] OVSR_CODE_FORMAT = 8'h20;
    localparam logic [7:0] OVSR_CODE_SETPOINT = 8'h21;
    localparam logic [7:0] OVSR_CODE_UPPER = 8'h24;

    // ----------------------------------------
    // Format byte layout
    // ----------------------------------------
    localparam int OVSR_FMT_MODE_LSB = 5;
    localparam logic [2:0] OVSR_FMT_MODE = 3'h0;
    localparam logic [4:0] OVSR_FMT_EXP = 5'h17;
    localparam logic [7:0] OVSR_FMT_VALUE = {OVSR_FMT_MODE, OVSR_FMT_EXP};

    // ----------------------------------------
    // Reset values and absolute bounds
    // ----------------------------------------
    localparam logic [15:0] OVSR_SP_RESET = 16'h0133;
    localparam logic [15:0] OVSR_SP_ABS_MAX = 16'h0B00;
    localparam logic [15:0] OVSR_MAX_R1 = 16'h034D;
    localparam logic [15:0] OVSR_UL_RESET = OVSR_MAX_R1;

    // ----------------------------------------
    // Divider ratio mantissas, exponent -2
    // ----------------------------------------
    localparam logic [2:0] OVSR_RATIO_ONE = 3'h4;
    localparam logic [2:0] OVSR_RATIO_HALF = 3'h2;
    localparam logic [2:0] OVSR_RATIO_QTR = 3'h1;
    localparam int OVSR_RATIO_SHIFT = 2;

    // ----------------------------------------
    // Per-ratio ranges in counts
    // ----------------------------------------
    localparam logic [15:0] OVSR_SP_MIN_R1 = 16'h00B3;
    localparam logic [15:0] OVSR_SP_MIN_R2 = 16'h0166;
    localparam logic [15:0] OVSR_SP_MIN_R4 = 16'h02CC;
    localparam logic [15:0] OVSR_MAX_R2 = 16'h069A;
    localparam logic [15:0] OVSR_UL_MIN_R1 = 16'h011A;
    localparam logic [15:0] OVSR_UL_MIN_R2 = 16'h0234;
    localparam logic [15:0] OVSR_UL_MIN_R4 = 16'h0468;
    localparam logic [15:0] OVSR_UL_MAX_R4 = 16'h0C00;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] wdata;
    } ovsr_req_t;

    typedef struct packed {
        logic ack;
        logic nack;
        logic [15:0] rdata;
    } ovsr_rsp_t;

    typedef struct packed {
        logic invalid_command_flag;
        logic ivd;
        logic cml;
        logic other_fault_flag;
        logic voltage_fault_warning_flag;
        logic vout_warn;
        logic alert;
    } ovsr_evt_t;

    // Range decoders, unknown ratios fall back to ratio one
    function automatic logic [15:0] ovsr_sp_min(input logic [2:0] r);
        return (r == OVSR_RATIO_HALF) ? OVSR_SP_MIN_R2 :
               (r == OVSR_RATIO_QTR) ? OVSR_SP_MIN_R4 : OVSR_SP_MIN_R1;
    endfunction : ovsr_sp_min

    function automatic logic [15:0] ovsr_sp_max(input logic [2:0] r);
        return (r == OVSR_RATIO_HALF) ? OVSR_MAX_R2 :
               (r == OVSR_RATIO_QTR) ? OVSR_SP_ABS_MAX : OVSR_MAX_R1;
    endfunction : ovsr_sp_max

    function automatic logic [15:0] ovsr_ul_min(input logic [2:0] r);
        return (r == OVSR_RATIO_HALF) ? OVSR_UL_MIN_R2 :
               (r == OVSR_RATIO_QTR) ? OVSR_UL_MIN_R4 : OVSR_UL_MIN_R1;
    endfunction : ovsr_ul_min

    function automatic logic [15:0] ovsr_ul_max(input logic [2:0] r);
        return (r == OVSR_RATIO_HALF) ? OVSR_MAX_R2 :
               (r == OVSR_RATIO_QTR) ? OVSR_UL_MAX_R4 : OVSR_MAX_R1;
    endfunction : ovsr_ul_max

endpackage : ovsr_pkg

// File: rtl/ovsr_target_calc.sv
`timescale 1ns/10ps
module ovsr_target_calc (
    input wire logic [15:0] setpoint_in,
    input wire logic [15:0] upper_in,
    input wire logic [15:0] lower_in,
    input wire logic [1:0] op_margin_in,
    input wire logic [15:0] trim_in,
    input wire logic [15:0] margin_up_step_in,
    input wire logic [15:0] margin_down_step_in,
    input wire logic [2:0] scale_mant_in,
    output logic [15:0] target_out,
    output logic [15:0] ref_out,
    output logic viol_out
);
    import ovsr_pkg::*;

    logic signed [18:0] sum;
    logic [15:0] clamped;
    logic [18:0] prod;

    // ----------------------------------------
    // Effective target, trim is signed counts
    // ----------------------------------------
    always_comb begin
        sum = 19'(signed'({3'b000, setpoint_in}));
        sum = sum + 19'(signed'(trim_in)); // RULE12
        if (op_margin_in == 2'b10) begin
            sum = sum + 19'(signed'({3'b000, margin_up_step_in}));
        end else if (op_margin_in == 2'b01) begin
            sum = sum - 19'(signed'({3'b000, margin_down_step_in}));
        end
        // Saturate so a deep negative trim cannot wrap high
        if (sum < 0) begin
            target_out = 16'h0000;
        end else if (sum > 19'sh0FFFF) begin
            target_out = 16'hFFFF;
        end else begin
            target_out = sum[15:0];
        end
    end

    // Conflicting limits resolve to the upper one
    always_comb begin
        viol_out = 1'b1;
        if (upper_in <= lower_in) begin
            clamped = upper_in; // RULE14
        end else if (target_out > upper_in) begin
            clamped = upper_in; // RULE12
        end else if (target_out < lower_in) begin
            clamped = lower_in; // RULE18
        end else begin
            clamped = target_out;
            viol_out = 1'b0;
        end
    end

    // Reference in counts scaled by the divider ratio
    assign prod = 19'(clamped) * 19'(scale_mant_in); // RULE13
    assign ref_out = prod[15 + OVSR_RATIO_SHIFT:OVSR_RATIO_SHIFT];

endmodule : ovsr_target_calc

// File: rtl/ovsr_regs.sv
// Behaviour
// RULE1 - Format byte: three-bit mode, five-bit exponent
// RULE2 - Format mode field always reads 000
// RULE3 - Format exponent field always reads 10111
// RULE4 - Host writes never change format fields
// RULE5 - Loop slave: NACK, invalid command, alert
// RULE6 - Store-all command saves the setpoint
// RULE7 - Setpoint and limit are unsigned mantissas
// RULE8 - Setpoint range follows the divider ratio
// RULE9 - Setpoint above 2816 rejected as invalid
// RULE10 - Setpoint beyond a limit replaced by it
// RULE11 - Setpoint resets to 0x0133
// RULE12 - Upper limit bounds every target change; code clamps the reference only, not the effective target output
// RULE13 - Reference ceiling is limit times ratio
// RULE14 - Clamp to upper product, upper dominates
// RULE15 - Violation sets other, warning flags, alert
// RULE16 - Upper limit defaults 845, accepts 282-845
// RULE17 - Ratio is 1, 0.5 or 0.25
// RULE18 - Lower limit bounds every target change; code clamps the reference only, not the effective target output
// RULE19 - Reference recomputed within one cycle
`timescale 1ns/10ps
module ovsr_regs (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire ovsr_pkg::ovsr_req_t req_in,
    output ovsr_pkg::ovsr_rsp_t rsp_out,
    input wire logic loop_slave_in,
    input wire logic output_on_in,
    input wire logic [2:0] scale_mant_in,
    input wire logic [15:0] lower_limit_in,
    input wire logic [1:0] op_margin_in,
    input wire logic [15:0] trim_in,
    input wire logic [15:0] margin_up_step_in,
    input wire logic [15:0] margin_down_step_in,
    input wire logic store_all_in,
    output ovsr_pkg::ovsr_evt_t evt_out,
    output logic nvm_store_out,
    output logic [15:0] nvm_data_out,
    output logic [15:0] setpoint_out,
    output logic [15:0] upper_limit_out,
    output logic [15:0] effective_voltage_target_out,
    output logic [15:0] ref_out,
    output logic clamp_active_out
);
    import ovsr_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] sp_q, sp_d;
    logic [15:0] ul_q, ul_d;
    ovsr_rsp_t rsp_q, rsp_d;
    ovsr_evt_t evt_q, evt_d;
    logic store_q, store_d;
    logic [15:0] nvm_q, nvm_d;
    logic [15:0] ref_q, ref_d;
    logic [15:0] tgt_q, tgt_d;
    logic viol_q, viol_d;

    logic hit;
    logic access;
    logic [15:0] calc_tgt;
    logic [15:0] calc_ref;
    logic calc_viol;
    logic viol_rise;
    logic [2:0] ratio;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Unknown ratio codes are refused upstream; treat as one here
    assign ratio = (scale_mant_in == OVSR_RATIO_HALF ||
                    scale_mant_in == OVSR_RATIO_QTR) ?
                   scale_mant_in : OVSR_RATIO_ONE; // RULE17
    assign access = req_in.wr | req_in.rd;
    assign hit = access && (req_in.code == OVSR_CODE_FORMAT ||
                            req_in.code == OVSR_CODE_SETPOINT ||
                            req_in.code == OVSR_CODE_UPPER);

    // ----------------------------------------
    // Target and reference
    // ----------------------------------------
    ovsr_target_calc u_calc (
        .setpoint_in(sp_q),
        .upper_in(ul_q),
        .lower_in(lower_limit_in),
        .op_margin_in(op_margin_in),
        .trim_in(trim_in),
        .margin_up_step_in(margin_up_step_in),
        .margin_down_step_in(margin_down_step_in),
        .scale_mant_in(ratio),
        .target_out(calc_tgt),
        .ref_out(calc_ref),
        .viol_out(calc_viol)
    );

    // Only a fresh violation is reported, not every cycle of it
    assign viol_rise = calc_viol & ~viol_q;

    // ----------------------------------------
    // Command handling
    // ----------------------------------------
    // A write wins over a read in the same request
    always_comb begin
        sp_d = sp_q;
        ul_d = ul_q;
        rsp_d = '0;
        evt_d = '0;
        if (hit && loop_slave_in) begin
            // Access refused, nothing is stored
            rsp_d.nack = 1'b1; // RULE5
            evt_d.invalid_command_flag = 1'b1; // RULE5
            evt_d.cml = 1'b1;
        end else if (hit) begin
            case (req_in.code)
                OVSR_CODE_FORMAT: begin
                    // Writes are acknowledged but discarded
                    rsp_d.ack = 1'b1; // RULE4
                    if (!req_in.wr) begin
                        rsp_d.rdata = {8'h00, OVSR_FMT_VALUE}; // RULE1 RULE2 RULE3
                    end
                end
                OVSR_CODE_SETPOINT: begin
                    if (!req_in.wr) begin
                        rsp_d.ack = 1'b1;
                        rsp_d.rdata = sp_q; // RULE7
                    end else if (req_in.wdata > OVSR_SP_ABS_MAX ||
                                 req_in.wdata > ovsr_sp_max(ratio) ||
                                 req_in.wdata < ovsr_sp_min(ratio)) begin
                        rsp_d.nack = 1'b1; // RULE8 RULE9
                        evt_d.ivd = 1'b1; // RULE9
                        evt_d.cml = 1'b1; // RULE9
                    end else begin
                        rsp_d.ack = 1'b1;
                        if (req_in.wdata > ul_q) begin
                            sp_d = ul_q; // RULE10
                        end else if (req_in.wdata < lower_limit_in) begin
                            sp_d = lower_limit_in; // RULE10
                        end else begin
                            sp_d = req_in.wdata;
                        end
                    end
                end
                OVSR_CODE_UPPER: begin
                    if (!req_in.wr) begin
                        rsp_d.ack = 1'b1;
                        rsp_d.rdata = ul_q;
                    end else if (req_in.wdata > ovsr_ul_max(ratio) ||
                                 req_in.wdata < ovsr_ul_min(ratio)) begin
                        rsp_d.nack = 1'b1; // RULE16
                        evt_d.ivd = 1'b1;
                        evt_d.cml = 1'b1;
                    end else begin
                        rsp_d.ack = 1'b1;
                        ul_d = req_in.wdata; // RULE16
                    end
                end
                default: begin
                    rsp_d = '0;
                end
            endcase
        end
        // Limit violation flags only count while the output runs
        if (viol_rise && output_on_in) begin
            evt_d.other_fault_flag = 1'b1; // RULE15
            evt_d.voltage_fault_warning_flag = 1'b1; // RULE15
            evt_d.vout_warn = 1'b1; // RULE15
        end
        evt_d.alert = evt_d.invalid_command_flag | evt_d.ivd |
                      evt_d.other_fault_flag; // RULE5 RULE15
    end

    // ----------------------------------------
    // Store and reference update
    // ----------------------------------------
    // Setpoint snapshot travels with the store pulse
    always_comb begin
        store_d = store_all_in; // RULE6
        nvm_d = store_all_in ? sp_q : nvm_q; // RULE6
        ref_d = calc_ref; // RULE19
        tgt_d = calc_tgt; // RULE19
        viol_d = calc_viol;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sp_q <= OVSR_SP_RESET; // RULE11
            ul_q <= OVSR_UL_RESET; // RULE16
            rsp_q <= '0;
            evt_q <= '0;
            store_q <= 1'b0;
            nvm_q <= '0;
            ref_q <= '0;
            tgt_q <= '0;
            viol_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            ul_q <= ul_d;
            rsp_q <= rsp_d;
            evt_q <= evt_d;
            store_q <= store_d;
            nvm_q <= nvm_d;
            ref_q <= ref_d;
            tgt_q <= tgt_d;
            viol_q <= viol_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rsp_out = rsp_q;
    assign evt_out = evt_q;
    assign nvm_store_out = store_q;
    assign nvm_data_out = nvm_q;
    assign setpoint_out = sp_q;
    assign upper_limit_out = ul_q;
    assign effective_voltage_target_out = tgt_q;
    assign ref_out = ref_q;
    assign clamp_active_out = viol_q; // RULE14

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    // Helper: ceiling of the reference for the current limit
    logic [18:0] lim_prod;
    assign lim_prod = 19'(ul_q) * 19'(ratio);

    sequence s_slave_hit;
        hit && loop_slave_in;
    endsequence

    sequence s_refused;
        rsp_out.nack && !rsp_out.ack && evt_out.invalid_command_flag && evt_out.alert;
    endsequence

    sequence s_sp_wr;
        hit && !loop_slave_in && req_in.wr && req_in.code == OVSR_CODE_SETPOINT;
    endsequence

    sequence s_ul_wr;
        hit && !loop_slave_in && req_in.wr && req_in.code == OVSR_CODE_UPPER;
    endsequence

    a_fmt_read_value: assert property ( // RULE2
        hit && !loop_slave_in && !req_in.wr && req_in.code == OVSR_CODE_FORMAT
        |=> rsp_out.ack && rsp_out.rdata == 16'h0017)
        else $error("format read returned wrong value");

    a_fmt_write_keep: assert property ( // RULE4
        hit && !loop_slave_in && req_in.wr && req_in.code == OVSR_CODE_FORMAT
        |=> rsp_out.ack && !rsp_out.nack && $stable(sp_q) && $stable(ul_q))
        else $error("format write disturbed state");

    a_slave_refuse: assert property ( // RULE5
        s_slave_hit |=> s_refused ##0 $stable(sp_q) && $stable(ul_q))
        else $error("loop slave access not refused");

    a_sp_high_reject: assert property ( // RULE9
        s_sp_wr ##0 req_in.wdata > 16'h0B00
        |=> rsp_out.nack && evt_out.ivd && evt_out.cml && $stable(sp_q))
        else $error("oversize setpoint not rejected");

    a_sp_clamp_upper: assert property ( // RULE10
        s_sp_wr ##0 req_in.wdata <= 16'h0B00 && req_in.wdata > ul_q &&
        req_in.wdata <= ovsr_sp_max(ratio) && req_in.wdata >= ovsr_sp_min(ratio)
        |=> sp_q == $past(ul_q))
        else $error("setpoint not replaced by upper limit");

    a_store_snapshot: assert property ( // RULE6
        store_all_in |=> nvm_store_out && nvm_data_out == $past(sp_q))
        else $error("store pulse lost setpoint");

    a_ref_ceiling: assert property ( // RULE13
        ##1 ref_out <= $past(lim_prod[17:2]))
        else $error("reference above upper limit product");

    a_limit_alert: assert property ( // RULE15
        viol_rise && output_on_in
        |=> evt_out.other_fault_flag && evt_out.voltage_fault_warning_flag &&
        evt_out.vout_warn && evt_out.alert)
        else $error("limit violation not reported");

    a_upper_range: assert property ( // RULE16
        hit && !loop_slave_in && req_in.wr && req_in.code == OVSR_CODE_UPPER &&
        ratio == 3'h4 ##1 rsp_out.ack
        |-> ul_q >= 16'h011A && ul_q <= 16'h034D)
        else $error("upper limit outside range");

    a_off_no_flag: assert property ( // RULE15
        !output_on_in && !hit |=> !evt_out.other_fault_flag && !evt_out.alert)
        else $error("flag raised while output off");

    // Registers come back to their defaults on every reset
    a_reset_defaults: assert property ( // RULE11
        $rose(rst_n_in) |-> sp_q == 16'h0133 && ul_q == 16'h034D)
        else $error("register defaults wrong after reset");

    // Setpoint words: stored, pulled to the lower limit, or refused
    a_sp_in_range: assert property ( // RULE8
        s_sp_wr ##0 req_in.wdata >= ovsr_sp_min(ratio) &&
        req_in.wdata <= ovsr_sp_max(ratio) && req_in.wdata <= ul_q &&
        req_in.wdata >= lower_limit_in
        |=> rsp_out.ack && sp_q == $past(req_in.wdata))
        else $error("valid setpoint not stored");

    a_sp_clamp_lower: assert property ( // RULE10
        s_sp_wr ##0 req_in.wdata >= ovsr_sp_min(ratio) &&
        req_in.wdata <= ovsr_sp_max(ratio) && req_in.wdata <= ul_q &&
        req_in.wdata < lower_limit_in
        |=> rsp_out.ack && sp_q == $past(lower_limit_in))
        else $error("setpoint not raised to lower limit");

    a_sp_range_reject: assert property ( // RULE8
        s_sp_wr ##0 (req_in.wdata < ovsr_sp_min(ratio) || req_in.wdata > ovsr_sp_max(ratio))
        |=> rsp_out.nack && !rsp_out.ack && evt_out.ivd && $stable(sp_q))
        else $error("out of range setpoint not refused");

    // Upper limit words: stored in range, refused outside it
    a_ul_store: assert property ( // RULE16
        s_ul_wr ##0 req_in.wdata >= ovsr_ul_min(ratio) && req_in.wdata <= ovsr_ul_max(ratio)
        |=> rsp_out.ack && ul_q == $past(req_in.wdata))
        else $error("valid upper limit not stored");

    a_ul_reject: assert property ( // RULE16
        s_ul_wr ##0 (req_in.wdata < ovsr_ul_min(ratio) || req_in.wdata > ovsr_ul_max(ratio))
        |=> rsp_out.nack && evt_out.ivd && $stable(ul_q))
        else $error("out of range upper limit not refused");

    // Crossed limits hold the reference at the upper product
    a_limit_conflict: assert property ( // RULE14
        ul_q <= lower_limit_in
        |=> clamp_active_out && ref_out == $past(lim_prod[17:2]))
        else $error("crossed limits not clamped to upper");

    // No store pulse and no new snapshot without the command
    a_nvm_quiet: assert property ( // RULE6
        !store_all_in |=> !nvm_store_out && $stable(nvm_data_out))
        else $error("store pulse without command");

endmodule : ovsr_regs

// File: tb/ovsr_host_model.sv
`timescale 1ns/10ps
module ovsr_host_model (
    input wire logic clk_sys_in,
    output ovsr_pkg::ovsr_req_t req_out,
    input wire ovsr_pkg::ovsr_rsp_t rsp_in
);
    import ovsr_pkg::*;

    // Idle bus shows no strobe
    initial begin
        req_out = '0;
    end

    // One command per call; the strobe stands for the single edge that takes it.
    // Released lines carry inverted values so stale data is never mistaken for live.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
                        output ovsr_rsp_t rsp);
        @(posedge clk_sys_in);
        req_out <= '{wr: wr, rd: !wr, code: code, wdata: wdata};
        @(posedge clk_sys_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~wdata};
        #1;
        rsp = rsp_in;
    endtask : xfer
endmodule : ovsr_host_model

// File: tb/tb_ovsr_regs.sv
`timescale 1ns/10ps
module tb_ovsr_regs;
    import ovsr_pkg::*;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic loop_slave = 1'b0;
    logic output_on = 1'b0;
    logic [2:0] scale = OVSR_RATIO_ONE;
    logic [15:0] lower = 16'h0000;
    logic [1:0] op_margin = 2'b00;
    logic [15:0] trim = 16'h0000;
    logic [15:0] step_up = 16'h0000;
    logic [15:0] step_dn = 16'h0000;
    logic store_all = 1'b0;
    ovsr_req_t req;
    ovsr_rsp_t rsp;
    ovsr_rsp_t r;
    ovsr_evt_t evt;
    logic nvm_store;
    logic [15:0] nvm_data;
    logic [15:0] setpoint;
    logic [15:0] upper;
    logic [15:0] target;
    logic [15:0] vref;
    logic clamp;
    logic seen;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    // Per-ratio bounds, order one, half, quarter
    logic [2:0] ratios [3] = '{OVSR_RATIO_ONE, OVSR_RATIO_HALF, OVSR_RATIO_QTR};
    logic [15:0] sp_lo [3] = '{16'h00B3, 16'h0166, 16'h02CC};
    logic [15:0] sp_hi [3] = '{16'h034D, 16'h069A, 16'h0B00};
    logic [15:0] ul_hi [3] = '{16'h034D, 16'h069A, 16'h0C00};
    logic [7:0] codes [3] = '{OVSR_CODE_FORMAT, OVSR_CODE_SETPOINT, OVSR_CODE_UPPER};

    always #10 clk_sys_in = ~clk_sys_in;

    ovsr_host_model ovsr_host_model_i (
        .clk_sys_in(clk_sys_in),
        .req_out(req),
        .rsp_in(rsp)
    );

    ovsr_regs ovsr_regs_i (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .req_in(req),
        .rsp_out(rsp),
        .loop_slave_in(loop_slave),
        .output_on_in(output_on),
        .scale_mant_in(scale),
        .lower_limit_in(lower),
        .op_margin_in(op_margin),
        .trim_in(trim),
        .margin_up_step_in(step_up),
        .margin_down_step_in(step_dn),
        .store_all_in(store_all),
        .evt_out(evt),
        .nvm_store_out(nvm_store),
        .nvm_data_out(nvm_data),
        .setpoint_out(setpoint),
        .upper_limit_out(upper),
        .effective_voltage_target_out(target),
        .ref_out(vref),
        .clamp_active_out(clamp)
    );

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic test_done();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] seen_v, input logic [15:0] exp);
        num_checks++;
        if (seen_v !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen_v);
        end
    endtask : chk

    // One command with its answer, read data on reads, and event pulse
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] d,
                       input logic ok, input logic [6:0] ev);
        ovsr_host_model_i.xfer(wr, code, d, r);
        chk("answer", {r.ack, r.nack}, ok ? 2'b10 : 2'b01);
        chk("events", evt, ev);
        if (!wr) begin
            chk("read data", r.rdata, d);
        end
    endtask : cmd

    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        chk("setpoint", setpoint, 16'h0133);
        chk("upper", upper, 16'h034D);
        cmd(1'b0, OVSR_CODE_FORMAT, 16'h0017, 1'b1, 7'h00);
        cmd(1'b1, OVSR_CODE_FORMAT, 16'hFFE8, 1'b1, 7'h00);
        cmd(1'b0, OVSR_CODE_FORMAT, 16'h0017, 1'b1, 7'h00);
        // Accepted word lands with the answer, reference one edge later
        cmd(1'b1, OVSR_CODE_SETPOINT, 16'h0200, 1'b1, 7'h00);
        chk("setpoint", setpoint, 16'h0200);
        cmd(1'b0, OVSR_CODE_SETPOINT, 16'h0200, 1'b1, 7'h00);
        @(posedge clk_sys_in);
        #1;
        chk("reference", vref, 16'h0200);
        // Range edges for every ratio; one past the top is refused
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys_in);
            scale <= ratios[i];
            cmd(1'b1, OVSR_CODE_UPPER, ul_hi[i], 1'b1, 7'h00);
            cmd(1'b1, OVSR_CODE_SETPOINT, sp_lo[i], 1'b1, 7'h00);
            cmd(1'b1, OVSR_CODE_SETPOINT, sp_lo[i] - 16'h0001, 1'b0, 7'h31);
            cmd(1'b1, OVSR_CODE_SETPOINT, sp_hi[i] + 16'h0001, 1'b0, 7'h31);
            chk("setpoint", setpoint, sp_lo[i]);
            cmd(1'b1, OVSR_CODE_SETPOINT, sp_hi[i], 1'b1, 7'h00);
            chk("setpoint", setpoint, sp_hi[i]);
        end
        cmd(1'b1, OVSR_CODE_UPPER, 16'h0C01, 1'b0, 7'h31);
        @(posedge clk_sys_in);
        scale <= OVSR_RATIO_ONE;
        cmd(1'b1, OVSR_CODE_UPPER, 16'h0119, 1'b0, 7'h31);
        cmd(1'b1, OVSR_CODE_UPPER, 16'h0200, 1'b1, 7'h00);
        cmd(1'b0, OVSR_CODE_UPPER, 16'h0200, 1'b1, 7'h00);
        chk("upper", upper, 16'h0200);
        // Written setpoint is pulled back inside the limits
        cmd(1'b1, OVSR_CODE_SETPOINT, 16'h0300, 1'b1, 7'h00);
        chk("setpoint", setpoint, 16'h0200);
        @(posedge clk_sys_in);
        lower <= 16'h0190;
        cmd(1'b1, OVSR_CODE_SETPOINT, 16'h00C0, 1'b1, 7'h00);
        chk("setpoint", setpoint, 16'h0190);
        // Loop slave refuses every command of the block
        @(posedge clk_sys_in);
        loop_slave <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            cmd(1'b1, codes[i], 16'h0180, 1'b0, 7'h51);
            cmd(1'b0, codes[i], 16'h0000, 1'b0, 7'h51);
        end
        chk("setpoint", setpoint, 16'h0190);
        @(posedge clk_sys_in);
        loop_slave <= 1'b0;
        store_all <= 1'b1;
        @(posedge clk_sys_in);
        store_all <= 1'b0;
        #1;
        chk("store pulse", nvm_store, 1'b1);
        chk("store data", nvm_data, 16'h0190);
        // Margin step pushes the target past the upper limit while running
        @(posedge clk_sys_in);
        lower <= 16'h0000;
        output_on <= 1'b1;
        step_up <= 16'h0100;
        op_margin <= 2'b10;
        seen = 1'b0;
        for (int k = 0; k < 4 && !seen; k++) begin
            @(posedge clk_sys_in);
            #1;
            seen = (evt === 7'h0F);
        end
        chk("limit event", seen, 1'b1);
        @(posedge clk_sys_in);
        #1;
        chk("events", evt, 7'h00);
        chk("target", target, 16'h0290);
        chk("reference", vref, 16'h0200);
        chk("clamp", clamp, 1'b1);
        // Margin down and a negative trim pull the target in range
        @(posedge clk_sys_in);
        op_margin <= 2'b01;
        step_dn <= 16'h0100;
        trim <= 16'hFFF0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk("target", target, 16'h0080);
        chk("reference", vref, 16'h0080);
        chk("clamp", clamp, 1'b0);
        // Crossed limits: upper still wins
        @(posedge clk_sys_in);
        op_margin <= 2'b00;
        lower <= 16'h0300;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("reference", vref, 16'h0200);
        chk("clamp", clamp, 1'b1);
        // Reference scales with the divider ratio
        @(posedge clk_sys_in);
        scale <= OVSR_RATIO_HALF;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk("reference", vref, 16'h0100);
        // Mid-run reset brings the defaults back; output off avoids a stale event
        @(posedge clk_sys_in);
        output_on <= 1'b0;
        rst_n_in <= 1'b0;
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        chk("setpoint", setpoint, 16'h0133);
        chk("upper", upper, 16'h034D);
        test_done();
    end
endmodule : tb_ovsr_regs
